// ==== rtl/usbirq_pkg.sv ====
// Constants, types and behaviour notes for the USB device interrupt outputs
// Notes on behaviour
// - Frame start, device state, control, empty, not-ready, ready each get routing bits.
// - Routing bit 0 selects pin a, 1 selects pin b; vbus, wake at 15, 14.
// - Ready clear mode 0 clears on buffer done; mode 1 only by writing zero or by bus reset.
// - Sense 0 gives edge signalling with chosen polarity; sense 1 gives level.
// - Edge mode: a flag clear negates the pin once, then re-asserts if pending.
// - Edge-mode negate lasts 32 cycles of 48 MHz, about 667 ns.
// - With the core clock stopped no negate interval is produced.
// - Level mode: pin stays asserted until every routed flag is cleared.
// - Polarity 0 means falling edge or low level; 1 means rising or high.
// - Interrupt enable register at index 0x10, zero after hard or soft reset.
// - Enable bits 15..12 gate vbus, wake, frame start, device state requests.
// - Enable bits 11..8 gate control, empty, not-ready and ready requests.
// - Vbus and wake enables stay readable and writable with core clock stopped.
// - Qualifiers 7..4 gate device state flag on reset, address, config, suspend.
// - Setup stage completion always sets the control flag.
// - Bus reset reinitialises control and ready flags whatever the qualifier says.
package usbirq_pkg;
	localparam logic [7:0]  IDX_PIN_SETUP = 8'h0e;
	localparam logic [7:0]  IDX_ENABLE    = 8'h10;
	localparam logic [7:0]  IDX_FLAGS     = 8'h20;
	localparam logic [7:0]  IDX_STATUS    = 8'h21;
	localparam logic [7:0]  IDX_MASK      = 8'h22;
	localparam logic [15:0] ENABLE_RST    = 16'h0000;
	localparam logic [15:0] SETUP_RST     = 16'h0000;
	localparam logic [15:0] SETUP_WMASK   = 16'hff07;
	localparam int          SET_POL       = 0;
	localparam int          SET_SENSE     = 1;
	localparam int          SET_READY_CLEAR_MODE      = 2;
	localparam int          FLG_DEV       = 0;
	localparam int          FLG_CTRL      = 1;
	localparam int          FLG_READY_LSB = 8;
	localparam int          ST_PIN_A      = 0;
	localparam int          ST_PIN_B      = 1;
	localparam int          ST_BUS_RESET  = 2;
	localparam int          ST_CONFLICT   = 3;
	localparam logic [3:0]  STATUS_RST    = 4'h0;
	localparam logic [3:0]  MASK_RST      = 4'h0;
	localparam logic        PIN_RST       = 1'b1;
	localparam int          CLK_MHZ       = 100;
	localparam int          REF_MHZ       = 48;
	localparam int          NEG_REF_CYC   = 32;
	localparam int          NEG_TIME_NS   = 667;
	localparam logic [6:0]  NEG_CYC       =
		7'((NEG_REF_CYC * CLK_MHZ + REF_MHZ - 1) / REF_MHZ);

	typedef struct packed {
		logic vbus;
		logic wake;
		logic frame_start;
		logic buf_empty;
		logic buf_notready;
	} usbirq_src_type;

	typedef struct packed {
		logic bus_reset;
		logic set_addr_done;
		logic set_config_done;
		logic sleep_detect;
		logic setup_done;
		logic ctrl_write_status;
		logic ctrl_read_status;
		logic ctrl_done;
		logic ctrl_seq_error;
	} usbirq_evt_type;

	typedef struct packed {
		logic [15:0] enable;
		logic [15:0] setup;
		logic        dev_flag;
		logic        ctrl_flag;
		logic [6:0]  ready;
		logic [3:0]  status;
		logic [3:0]  mask;
		logic [6:0]  neg_cnt;
		logic        req_a_q;
		logic        req_b_q;
		logic        pin_a;
		logic        pin_b;
		logic        irq;
		logic        wr_pend;
		logic        wr_ok;
		logic [7:0]  wr_idx;
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} usbirq_state_type;
endpackage : usbirq_pkg

// ==== rtl/usbirq_top.sv ====
// AHB-Lite interrupt output stage of a full-speed USB device controller
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module usbirq_top
(
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	input  wire logic                 soft_reset,
	input  wire logic                 core_clk_run,
	input  wire logic                 frame_pulse_out_en,
	input  wire usbirq_pkg::usbirq_src_type src,
	input  wire usbirq_pkg::usbirq_evt_type evt,
	input  wire logic [6:0]           ep_ready_set,
	input  wire logic [6:0]           ep_buf_done,
	input  wire logic                 src_flag_clear,
	output logic                      irq_pin_a,
	output logic                      irq_pin_b,
	output logic                      irq
);
	import usbirq_pkg::*;

	usbirq_state_type st;
	usbirq_state_type next_st;
	logic [7:0]       flags;
	logic             req_a;
	logic             req_b;
	logic             addr_take;
	logic             wr_now;
	logic             neg_trig;
	logic             dev_set;
	logic             ctrl_set;
	logic [3:0]       st_set;

	function automatic logic [31:0] read_word(input usbirq_state_type s,
		input logic [7:0] idx);
		logic [31:0] w;
		w = 32'h0;
		case (idx)
			IDX_PIN_SETUP: w = {16'h0, s.setup};
			IDX_ENABLE:    w = {16'h0, s.enable};
			IDX_FLAGS:     w = {17'h0, s.ready, 6'h0, s.ctrl_flag, s.dev_flag};
			IDX_STATUS:    w = {28'h0, s.status};
			IDX_MASK:      w = {28'h0, s.mask};
			default:       w = 32'h0;
		endcase
		return w;
	endfunction : read_word

	function automatic logic shape(input logic req, input logic pol,
		input logic edge_mode, input logic negating);
		logic act;
		act = req && !(edge_mode && negating);
		return act ? pol : !pol;
	endfunction : shape

	// Flags in enable-bit order 15..8
	assign flags = {src.vbus, src.wake, src.frame_start, st.dev_flag,
		st.ctrl_flag, src.buf_empty, src.buf_notready, |st.ready};
	assign req_a = |(flags & st.enable[15:8] & ~st.setup[15:8]);
	assign req_b = |(flags & st.enable[15:8] & st.setup[15:8]);

	assign addr_take = hsel && htrans[1] && hready;
	assign wr_now    = st.wr_pend && st.wr_ok;

	// A flags register write or a flag owner clear opens a negate window, in edge mode with the core clock running
	assign neg_trig = core_clk_run && !st.setup[SET_SENSE] &&
		(src_flag_clear || (wr_now && st.wr_idx == IDX_FLAGS));

	assign dev_set = (evt.bus_reset && st.enable[7]) ||
		(evt.set_addr_done && st.enable[6]) ||
		(evt.set_config_done && st.enable[5]) ||
		(evt.sleep_detect && st.enable[4]);
	assign ctrl_set = evt.setup_done ||
		(evt.ctrl_write_status && st.enable[3]) ||
		(evt.ctrl_read_status && st.enable[2]) ||
		(evt.ctrl_done && st.enable[1]) ||
		(evt.ctrl_seq_error && st.enable[0]);

	always_comb
	begin
		next_st = st;
		st_set = 4'h0;
		st_set[ST_PIN_A] = req_a && !st.req_a_q;
		st_set[ST_PIN_B] = req_b && !st.req_b_q;
		st_set[ST_BUS_RESET] = evt.bus_reset;
		// Pin b doubles as the frame pulse output
		st_set[ST_CONFLICT] = frame_pulse_out_en &&
			|(st.setup[15:8] & st.enable[15:8]);
		next_st.req_a_q = req_a;
		next_st.req_b_q = req_b;

		// Register writes, applied in the data phase
		if (wr_now)
		begin
			case (st.wr_idx)
				IDX_PIN_SETUP: next_st.setup = hwdata[15:0] & SETUP_WMASK;
				// Register-only path, independent of core_clk_run
				IDX_ENABLE:    next_st.enable = hwdata[15:0];
				IDX_FLAGS:
				begin
					if (!hwdata[FLG_DEV])
						next_st.dev_flag = 1'b0;
					if (!hwdata[FLG_CTRL])
						next_st.ctrl_flag = 1'b0;
					if (st.setup[SET_READY_CLEAR_MODE])
						next_st.ready = st.ready &
							hwdata[FLG_READY_LSB +: 7];
				end
				IDX_STATUS:    next_st.status = st.status & ~hwdata[3:0];
				IDX_MASK:      next_st.mask = hwdata[3:0];
				default:       next_st.setup = st.setup;
			endcase
		end

		// Bus reset reinitialises the transfer flags
		if (evt.bus_reset)
		begin
			next_st.ctrl_flag = 1'b0;
			next_st.ready = 7'h0;
		end
		if (!st.setup[SET_READY_CLEAR_MODE])
			next_st.ready = next_st.ready & ~ep_buf_done;
		// Hardware set wins over any clear in the same cycle
		next_st.ready = next_st.ready | ep_ready_set;
		if (dev_set)
			next_st.dev_flag = 1'b1;
		if (ctrl_set)
			next_st.ctrl_flag = 1'b1;
		next_st.status = next_st.status | st_set;

		if (soft_reset)
		begin
			next_st.enable = ENABLE_RST;
			next_st.setup = SETUP_RST;
		end

		// Negate window, counted only while the core clock runs
		if (neg_trig)
			next_st.neg_cnt = NEG_CYC;
		else if (st.neg_cnt != 7'h0 && core_clk_run)
			next_st.neg_cnt = st.neg_cnt - 7'h1;
		if (!core_clk_run || st.setup[SET_SENSE])
			next_st.neg_cnt = 7'h0;

		next_st.pin_a = shape(req_a, st.setup[SET_POL],
			!st.setup[SET_SENSE], st.neg_cnt != 7'h0);
		next_st.pin_b = shape(req_b, st.setup[SET_POL],
			!st.setup[SET_SENSE], st.neg_cnt != 7'h0);
		next_st.irq = |(st.status & st.mask);

		// Address phase: capture write, answer reads with zero wait
		next_st.hreadyout = 1'b1;
		next_st.hresp = 1'b0;
		next_st.wr_pend = addr_take && hwrite;
		next_st.wr_ok = haddr[31:10] == 22'h0;
		next_st.wr_idx = haddr[9:2];
		if (addr_take && !hwrite)
		begin
			if (haddr[31:10] == 22'h0)
				next_st.hrdata = read_word(next_st, haddr[9:2]);
			else
				next_st.hrdata = 32'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st <= '{enable: ENABLE_RST, setup: SETUP_RST, dev_flag: 1'b0,
				ctrl_flag: 1'b0, ready: 7'h0, status: STATUS_RST,
				mask: MASK_RST, neg_cnt: 7'h0, req_a_q: 1'b0,
				req_b_q: 1'b0, pin_a: PIN_RST, pin_b: PIN_RST, irq: 1'b0,
				wr_pend: 1'b0, wr_ok: 1'b0, wr_idx: 8'h0,
				hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign hreadyout = st.hreadyout;
	assign hresp     = st.hresp;
	assign hrdata    = st.hrdata;
	assign irq_pin_a = st.pin_a;
	assign irq_pin_b = st.pin_b;
	assign irq       = st.irq;

	level_pin_a_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st.setup[SET_SENSE] && !(wr_now && st.wr_idx == IDX_PIN_SETUP)
		&& !soft_reset |=>
		irq_pin_a == ($past(req_a) ? st.setup[SET_POL] :
		!st.setup[SET_POL]))
		else $error("pin a level mode mismatch");

	level_pin_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st.setup[SET_SENSE] && $past(st.setup[SET_SENSE]) && !req_b
		&& $past(!req_b) |=> irq_pin_b == !$past(st.setup[SET_POL]))
		else $error("pin b not inactive in level mode");

	neg_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
		neg_trig && !soft_reset |=> st.neg_cnt == NEG_CYC)
		else $error("negate window not started");

	neg_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		neg_trig && !soft_reset && core_clk_run
		##1 (core_clk_run && !neg_trig && !st.setup[SET_SENSE])[*8] |->
		st.neg_cnt == NEG_CYC - 7'd7)
		else $error("negate window count wrong");

	neg_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st.neg_cnt != 7'h0 && !st.setup[SET_SENSE] |=>
		irq_pin_a == !$past(st.setup[SET_POL]))
		else $error("pin a active during negate");

	no_neg_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!core_clk_run |=> st.neg_cnt == 7'h0)
		else $error("negate window without core clock");

	setup_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		evt.setup_done |=> st.ctrl_flag)
		else $error("setup completion lost");

	dev_qual_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st.enable[7:4] == 4'h0 && !st.dev_flag |=> !st.dev_flag)
		else $error("device state flag set while unqualified");

	bus_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
		evt.bus_reset && !ctrl_set && ep_ready_set == 7'h0 |=>
		!st.ctrl_flag && st.ready == 7'h0)
		else $error("bus reset did not clear flags");

	ready_auto_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!st.setup[SET_READY_CLEAR_MODE] && (ep_buf_done & ~ep_ready_set) != 7'h0 |=>
		(st.ready & $past(ep_buf_done & ~ep_ready_set)) == 7'h0)
		else $error("ready flag not cleared on buffer done");

	soft_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
		soft_reset |=> st.enable == ENABLE_RST && st.setup == SETUP_RST)
		else $error("soft reset left enables set");

	irq_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(st.status & st.mask) != 4'h0 |=> irq)
		else $error("interrupt output not raised");

	// Bus side: zero wait, OKAY only
	bus_answer_a: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |-> hreadyout && !hresp)
		else $error("bus answer not ready or not okay");

	rd_enable_a: assert property (@(posedge hclk) disable iff (!hresetn)
		addr_take && !hwrite && haddr[31:10] == 22'h0 &&
		haddr[9:2] == IDX_ENABLE && !wr_now && !soft_reset |=>
		hrdata == {16'h0, $past(st.enable)})
		else $error("enable read data wrong");

	rd_unmapped_a: assert property (@(posedge hclk) disable iff (!hresetn)
		addr_take && !hwrite && haddr[31:10] != 22'h0 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");

	rd_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!(addr_take && !hwrite) |=> $stable(hrdata))
		else $error("read data changed without read");

	enable_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_now && st.wr_idx == IDX_ENABLE && !soft_reset |=>
		st.enable == $past(hwdata[15:0]))
		else $error("enable write lost");

	setup_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_now && st.wr_idx == IDX_PIN_SETUP && !soft_reset |=>
		st.setup == ($past(hwdata[15:0]) & SETUP_WMASK))
		else $error("pin setup write lost");

	setup_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!wr_now && !soft_reset |=> $stable(st.setup) && $stable(st.enable))
		else $error("setup or enable changed without write");

	// Flag owners
	dev_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_now && st.wr_idx == IDX_FLAGS && !hwdata[FLG_DEV] && !dev_set
		|=> !st.dev_flag)
		else $error("device state flag not cleared");

	ready_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st.setup[SET_READY_CLEAR_MODE] && !evt.bus_reset &&
		!(wr_now && st.wr_idx == IDX_FLAGS) |=>
		(st.ready & $past(st.ready)) == $past(st.ready))
		else $error("ready flag lost in write-clear mode");

	ready_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ep_ready_set != 7'h0 |=>
		(st.ready & $past(ep_ready_set)) == $past(ep_ready_set))
		else $error("ready flag not set");

	ctrl_qual_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st.enable[3:0] == 4'h0 && !evt.setup_done && !st.ctrl_flag |=>
		!st.ctrl_flag)
		else $error("control flag set while unqualified");

	dev_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		dev_set |=> st.dev_flag)
		else $error("qualified device state event lost");

	// Pin shaping
	level_act_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st.setup[SET_SENSE] && req_b && !soft_reset &&
		!(wr_now && st.wr_idx == IDX_PIN_SETUP) |=>
		irq_pin_b == st.setup[SET_POL])
		else $error("pin b not active in level mode");

	neg_pin_b_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st.neg_cnt != 7'h0 && !st.setup[SET_SENSE] |=>
		irq_pin_b == !$past(st.setup[SET_POL]))
		else $error("pin b active during negate");

	edge_act_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!st.setup[SET_SENSE] && st.neg_cnt == 7'h0 && req_a |=>
		irq_pin_a == $past(st.setup[SET_POL]))
		else $error("pin a not active in edge mode");

	neg_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st.neg_cnt != 7'h0 && core_clk_run && !neg_trig &&
		!st.setup[SET_SENSE] |=>
		st.neg_cnt == $past(st.neg_cnt) - 7'h1)
		else $error("negate window not counting down");

	neg_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |-> st.neg_cnt <= NEG_CYC)
		else $error("negate count out of range");

	level_no_neg_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st.setup[SET_SENSE] |=> st.neg_cnt == 7'h0)
		else $error("negate window in level mode");

	// Sticky status and summary output
	status_pin_a_a: assert property (@(posedge hclk) disable iff (!hresetn)
		req_a && !st.req_a_q |=> st.status[ST_PIN_A])
		else $error("pin a request edge not recorded");

	status_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_now && st.wr_idx == IDX_STATUS && hwdata[ST_PIN_A] &&
		!st_set[ST_PIN_A] |=> !st.status[ST_PIN_A])
		else $error("status bit not cleared by one");

	conflict_a: assert property (@(posedge hclk) disable iff (!hresetn)
		frame_pulse_out_en && |(st.setup[15:8] & st.enable[15:8]) |=>
		st.status[ST_CONFLICT])
		else $error("frame pulse conflict not recorded");

	irq_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(st.status & st.mask) == 4'h0 |=> !irq)
		else $error("interrupt output raised while masked");

	bus_reset_st_a: assert property (@(posedge hclk) disable iff (!hresetn)
		evt.bus_reset |=> st.status[ST_BUS_RESET])
		else $error("bus reset not recorded");

	edge_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
		neg_trig && req_a ##2 irq_pin_a == !st.setup[SET_POL]);
	level_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
		st.setup[SET_SENSE] && req_b ##1 irq_pin_b == st.setup[SET_POL]);
	irq_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(irq));
	neg_done_c: cover property (@(posedge hclk) disable iff (!hresetn)
		st.neg_cnt == 7'h1 ##1 st.neg_cnt == 7'h0);
	ready_mode_c: cover property (@(posedge hclk) disable iff (!hresetn)
		st.setup[SET_READY_CLEAR_MODE] && ep_buf_done != 7'h0);
endmodule : usbirq_top

// ==== verification/usb_device_irq_output_control_tb.sv ====
// Self-checking bench for the USB device interrupt output stage
`timescale 1ns/1ps
module usb_device_irq_output_control_tb;
	import usbirq_pkg::*;
	logic           hclk;
	logic           hresetn;
	logic           hsel;
	logic [31:0]    haddr;
	logic [1:0]     htrans;
	logic           hwrite;
	logic [2:0]     hsize;
	logic [31:0]    hwdata;
	logic           hreadyout;
	logic           hresp;
	logic [31:0]    hrdata;
	logic           soft_reset;
	logic           core_clk_run;
	logic           frame_pulse_out_en;
	usbirq_src_type src;
	usbirq_evt_type evt;
	logic [6:0]     ep_ready_set;
	logic [6:0]     ep_buf_done;
	logic           src_flag_clear;
	logic           irq_pin_a;
	logic           irq_pin_b;
	logic           irq;
	logic           pol;
	logic [31:0]    rdat;
	logic [31:0]    expv;
	logic [15:0]    qual;
	int             n_assert;
	int             inactive_len;
	int             na;
	int             n_mismatch = 0;
	int             checked = 0;
	int             ebit [5] = '{15, 14, 13, 10, 9};

	usbirq_top i_dut
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .soft_reset(soft_reset),
		.core_clk_run(core_clk_run), .frame_pulse_out_en(frame_pulse_out_en),
		.src(src), .evt(evt), .ep_ready_set(ep_ready_set),
		.ep_buf_done(ep_buf_done), .src_flag_clear(src_flag_clear),
		.irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b), .irq(irq)
	);

	usbirq_host i_host
	(
		.hclk(hclk), .hresetn(hresetn), .pin(irq_pin_a), .pol(pol),
		.frame_pulse_out_en(frame_pulse_out_en), .n_assert(n_assert),
		.inactive_len(inactive_len)
	);

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		for (int i = 0; i < 16 && hreadyout !== 1'b1; i++)
			@(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		for (int i = 0; i < 16 && hreadyout !== 1'b1; i++)
			@(posedge hclk);
		rdat = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		bus(1'b1, {22'h0, idx, 2'b00}, d);
	endtask : wr

	task automatic rd(input logic [7:0] idx);
		bus(1'b0, {22'h0, idx, 2'b00}, 32'h0);
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic rdy(input logic [6:0] s, input logic [6:0] d);
		ep_ready_set <= s;
		ep_buf_done  <= d;
		@(posedge hclk);
		ep_ready_set <= 7'h00;
		ep_buf_done  <= 7'h00;
		cyc(3);
	endtask : rdy

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	initial
	begin
		hclk = 1'b0;
		forever
			#5 hclk = ~hclk;
	end

	// Whole sequence needs well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge hclk);
		n_mismatch++;
		final_report();
	end

	initial
	begin
		{hresetn, hsel, hwrite, soft_reset, src_flag_clear} <= 5'h0;
		{haddr, hwdata, htrans, ep_ready_set, ep_buf_done} <= '0;
		{src, evt, pol} <= '0;
		hsize <= 3'b010;
		core_clk_run <= 1'b1;
		cyc(6);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(irq_pin_a, PIN_RST);
		rd(IDX_ENABLE);
		chk(rdat, ENABLE_RST);
		wr(IDX_ENABLE, 32'hffff);
		wr(IDX_PIN_SETUP, 32'hffff);
		rd(IDX_PIN_SETUP);
		chk(rdat, {16'h0, SETUP_WMASK});
		bus(1'b0, 32'h3c, 32'h0);
		chk(rdat, 32'h0);
		soft_reset <= 1'b1;
		@(posedge hclk);
		soft_reset <= 1'b0;
		rd(IDX_ENABLE);
		chk(rdat, 32'h0);
		rd(IDX_PIN_SETUP);
		chk(rdat, 32'h0);
		// Level mode, active high, one source at a time, then vbus and wake together
		pol <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			wr(IDX_ENABLE, 32'h1 << ebit[i]);
			wr(IDX_PIN_SETUP, (32'h1 << ebit[i]) | 32'h3);
			src <= usbirq_src_type'(5'h10 >> i);
			cyc(3);
			chk({irq_pin_b, irq_pin_a}, 2'b10);
			wr(IDX_PIN_SETUP, 32'h3);
			cyc(3);
			chk({irq_pin_b, irq_pin_a}, 2'b01);
			wr(IDX_ENABLE, 32'h0);
			cyc(3);
			chk(irq_pin_a, 1'b0);
		end
		wr(IDX_ENABLE, 32'hc000);
		src <= usbirq_src_type'(5'h18);
		cyc(3);
		src <= usbirq_src_type'(5'h08);
		cyc(3);
		chk(irq_pin_a, 1'b1);
		src <= '0;
		cyc(3);
		chk(irq_pin_a, 1'b0);
		for (int j = 0; j < 9; j++)
			for (int q = 0; q < 2; q++)
			begin
				qual = (j > 4) ? 16'h1 << (j - 1) : (j < 4) ? 16'h1 << j : 16'h0;
				wr(IDX_ENABLE, {16'h0, 16'h1800 | (q ? qual : 16'h0)});
				evt <= usbirq_evt_type'(9'h1 << j);
				@(posedge hclk);
				evt <= '0;
				cyc(3);
				expv = {30'h0, j == 4 || (q && j < 4), q && j > 4};
				rd(IDX_FLAGS);
				chk(rdat, expv);
				chk(irq_pin_a, |expv);
				wr(IDX_FLAGS, 32'h0);
			end
		wr(IDX_ENABLE, 32'h0);
		evt <= usbirq_evt_type'(9'h010);
		rdy(7'h01, 7'h00);
		evt <= usbirq_evt_type'(9'h100);
		@(posedge hclk);
		evt <= '0;
		cyc(3);
		rd(IDX_FLAGS);
		chk(rdat, 32'h0);
		wr(IDX_ENABLE, 32'h0100);
		rdy(7'h08, 7'h00);
		chk(irq_pin_a, 1'b1);
		wr(IDX_FLAGS, 32'h0);
		rd(IDX_FLAGS);
		chk(rdat, 32'h0800);
		rdy(7'h00, 7'h08);
		rd(IDX_FLAGS);
		chk(rdat, 32'h0);
		wr(IDX_PIN_SETUP, 32'h7);
		rdy(7'h08, 7'h08);
		rd(IDX_FLAGS);
		chk(rdat, 32'h0800);
		wr(IDX_FLAGS, 32'h0);
		rd(IDX_FLAGS);
		chk(rdat, 32'h0);
		// Active low, level then edge
		pol <= 1'b0;
		wr(IDX_PIN_SETUP, 32'h2);
		wr(IDX_ENABLE, 32'h8000);
		src <= usbirq_src_type'(5'h10);
		cyc(3);
		chk(irq_pin_a, 1'b0);
		wr(IDX_PIN_SETUP, 32'h0);
		for (int k = 0; k < 3; k++)
		begin
			core_clk_run <= (k < 2);
			na = n_assert;
			if (k == 1)
				wr(IDX_FLAGS, 32'h0);
			else
				begin
					src_flag_clear <= 1'b1;
					@(posedge hclk);
					src_flag_clear <= 1'b0;
				end
			cyc(80);
			chk(n_assert, na + (k < 2));
			if (k < 2)
				chk(inactive_len, 32'(NEG_CYC));
		end
		wr(IDX_ENABLE, 32'hc000);
		rd(IDX_ENABLE);
		chk(rdat, 32'hc000);
		core_clk_run <= 1'b1;
		// Sticky status, mask and summary output
		src <= '0;
		wr(IDX_ENABLE, 32'h0);
		wr(IDX_MASK, 32'h1);
		wr(IDX_STATUS, 32'hf);
		rd(IDX_STATUS);
		chk({rdat[3:0], irq}, 5'h0);
		wr(IDX_ENABLE, 32'h8000);
		src <= usbirq_src_type'(5'h10);
		cyc(4);
		rd(IDX_STATUS);
		chk({rdat[3:0], irq}, 5'h3);
		wr(IDX_MASK, 32'h0);
		cyc(2);
		chk(irq, 1'b0);
		wr(IDX_STATUS, 32'h1);
		rd(IDX_STATUS);
		chk(rdat, 32'h0);
		final_report();
	end
endmodule : usb_device_irq_output_control_tb

// ==== verification/usbirq_host.sv ====
// Host-side model that watches one interrupt pin as the service CPU would
`timescale 1ns/1ps
module usbirq_host
(
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic pin,
	input  wire logic pol,
	output logic      frame_pulse_out_en,
	output int        n_assert,
	output int        inactive_len
);
	logic prev;
	int   run;

	// Pin b carries interrupts here, so the frame pulse stays off
	assign frame_pulse_out_en = 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prev         <= 1'b1;
			run          <= 0;
			n_assert     <= 0;
			inactive_len <= 0;
		end
		else
		begin
			prev <= pin;
			run  <= (pin !== pol) ? run + 1 : 0;
			// Inactive run ending in an active edge is the negate window
			if (pin === pol && prev !== pol)
			begin
				n_assert     <= n_assert + 1;
				inactive_len <= run;
			end
		end
	end
endmodule : usbirq_host
